//--- src/issmc_defs.vh
// Constants shared by the two-wire serial port logic
`ifndef ISSMC_DEFS_VH
`define ISSMC_DEFS_VH
`define ISSMC_PH_IDLE    3'h0
`define ISSMC_PH_ADDR    3'h1
`define ISSMC_PH_ADDR2   3'h2
`define ISSMC_PH_RX      3'h3
`define ISSMC_PH_TX      3'h4
`define ISSMC_PH_SKIP    3'h5
`define ISSMC_BIT_LAST   4'h8
`define ISSMC_BIT_ACK    4'h9
`define ISSMC_GC_ADDR    8'h00
`define ISSMC_TEN_PREFIX 5'h1E
`define ISSMC_RST_ADDR   8'h00
`define ISSMC_RST_CKP    1'b1
`define ISSMC_MST_OP_CYC 8'h10
`endif

//--- src/issmc_top.v
// Two-wire serial port: slave stretching, general call, master event control, receive FIFO
`timescale 1ns/1ps
`include "issmc_defs.vh"

// Small synchronous FIFO with valid/ready on both sides
module issmc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             clr,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    // Honest full and empty come straight from the fill count
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap at DEPTH so non power-of-two depths also work
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else if (clr) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                    : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                    : rd_ptr_reg + 1'b1;
            if (push & ~pop)
                count_reg <= count_reg + 1'b1;
            else if (pop & ~push)
                count_reg <= count_reg - 1'b1;
        end
    end

    // Storage has no reset; only written words are ever read
    always @(posedge clk) begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end
endmodule // issmc_fifo

// Operation
// - Slave transmit stretches the clock automatically in 7- and 10-bit modes.
// - With stretch enable set, hold the clock after each received data byte.
// - 7-bit receive: buffer full at ninth falling edge clears clock release.
// - Clock release zero keeps the clock low until software sets it.
// - Buffer read before ninth falling edge leaves clock release set.
// - Software may set clock release regardless of buffer full.
// - 10-bit address bytes stretch via update-address; own-address write releases.
// - Update-address set after high address byte with write and after low byte.
// - Buffer-full stretching applies to data bytes only, never address bytes.
// - 7-bit transmit: empty buffer at ninth falling edge clears clock release.
// - Transmit buffer loaded before ninth falling edge: no clock stretch.
// - 10-bit transmit: third address byte with read enters transmit, no update-address.
// - Clock hold starts only after the clock is sampled low.
// - Clock hold lasts until release is set; others then free the line.
// - General call enable also matches the all-zero address.
// - General call loads the buffer, sets full, flags on ninth falling edge.
// - 10-bit general call skips second address byte and update-address.
// - Start and stop seen bits clear on reset and port disable.
// - Master mode refuses queued requests; early buffer write sets write collision.
// - Master mode flags start, stop, repeated start, bytes and acknowledges.
// - Master mode accepts six operations: start, restart, write, receive, ack, stop.
// - Stretch enable one: stretch both directions; zero: transmit only.
// - Sample bits on rising clock, compare address at eighth falling edge.
module issmc_top #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire       CORE_CLK,
    input  wire       RESETN,
    input  wire       SCL_IN,
    output wire       SCL_OUT,
    output wire       SCL_OE,
    input  wire       SDA_IN,
    output wire       SDA_OUT,
    output wire       SDA_OE,
    input  wire       PORT_ENABLE,
    input  wire       MASTER_MODE,
    input  wire       TEN_BIT_MODE,
    input  wire       STRETCH_ENABLE,
    input  wire       GENERAL_CALL_ENABLE,
    input  wire       OWN_ADDRESS_WR,
    input  wire [7:0] OWN_ADDRESS_DATA,
    output wire [7:0] OWN_ADDRESS,
    input  wire       CLOCK_RELEASE_WR,
    input  wire       CLOCK_RELEASE_DATA,
    output wire       CLOCK_RELEASE,
    output wire [7:0] RX_DATA,
    output wire       RX_VALID,
    input  wire       RX_READY,
    input  wire       TX_WRITE,
    input  wire [7:0] TX_DATA,
    output wire       TX_READY,
    output wire       BUFFER_FULL,
    output wire       UPDATE_ADDRESS_FLAG,
    output wire       READ_WRITE,
    output wire       START_SEEN,
    output wire       STOP_SEEN,
    output wire       PORT_IRQ_FLAG,
    input  wire       IRQ_CLEAR,
    output wire       WRITE_COLLISION,
    input  wire       WRITE_COLLISION_CLEAR,
    output wire       RECEIVE_OVERFLOW,
    input  wire       OVERFLOW_CLEAR,
    input  wire       MST_START_REQ,
    input  wire       MST_RSTART_REQ,
    input  wire       MST_RECV_REQ,
    input  wire       MST_ACK_REQ,
    input  wire       MST_STOP_REQ,
    output wire       MST_BUSY
);
    reg        scl_meta_reg, scl_sync_reg, scl_prev_reg;
    reg        sda_meta_reg, sda_sync_reg, sda_prev_reg;
    reg [2:0]  phase_reg;
    reg [3:0]  cnt_reg;
    reg [7:0]  shift_register;
    reg [7:0]  tx_shift_reg;
    reg [7:0]  own_address_reg;
    reg [7:0]  serial_buffer_reg;
    reg        tx_full_reg, tx_need_reg, clock_release_reg;
    reg        update_address_flag_reg, ua_hold_reg, addr_seq_reg;
    reg        scl_drive_reg, sda_drive_reg, rw_reg, ten_hi_reg;
    reg        irq_reg, write_collision_reg, ovf_reg, start_seen_reg, stop_seen_reg;
    reg        mst_busy_reg;
    reg [7:0]  mst_cnt_reg;
    wire       slave_on, master_on, scl_rise, scl_fall, start_det, stop_det;
    wire       fall8, fall9, gc_hit, own_hit, hit1, hit2, room, ack_now;
    wire       fifo_ready, rx_nonempty, ten_hi_byte, hold;
    wire       mst_req, mst_take, tx_accept, write_collision_set, irq_set, mst_done;

    // Address field compare on bits seven down to one
    function addr7_eq;
        input [7:0] a;
        input [7:0] b;
        begin
            addr7_eq = (a[7:1] == b[7:1]);
        end
    endfunction

    // Pins cross into the core clock through two flops before any use
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= 3'h7;
            {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= 3'h7;
        end else begin
            scl_meta_reg <= SCL_IN;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= SDA_IN;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    // Bus events seen on the synchronised lines
    assign slave_on  = PORT_ENABLE & ~MASTER_MODE;
    assign master_on = PORT_ENABLE & MASTER_MODE;
    assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
    assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
    assign fall8     = slave_on & scl_fall & (cnt_reg == `ISSMC_BIT_LAST);
    assign fall9     = slave_on & scl_fall & (cnt_reg == `ISSMC_BIT_ACK);

    // Address decisions; a read after the low byte matched means 10-bit transmit
    assign gc_hit      = GENERAL_CALL_ENABLE & (shift_register == `ISSMC_GC_ADDR);
    assign ten_hi_byte = TEN_BIT_MODE & (shift_register[7:3] == `ISSMC_TEN_PREFIX);
    assign own_hit     = addr7_eq(shift_register, own_address_reg);
    assign hit1 = gc_hit | (own_hit & (~TEN_BIT_MODE | (ten_hi_byte &
                  (~shift_register[0] | ten_hi_reg))));
    assign hit2 = (shift_register == own_address_reg);
    assign room = fifo_ready & ~ovf_reg;
    assign ack_now = fall8 & room & ((phase_reg == `ISSMC_PH_ADDR)  ? hit1 :
                                     (phase_reg == `ISSMC_PH_ADDR2) ? hit2 :
                                     (phase_reg == `ISSMC_PH_RX));

    // Received bytes queue here; a full queue withholds the acknowledge
    issmc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .clk       (CORE_CLK),
        .rst_n     (RESETN),
        .clr       (~PORT_ENABLE),
        .in_valid  (ack_now),
        .in_ready  (fifo_ready),
        .in_data   (shift_register),
        .out_valid (rx_nonempty),
        .out_ready (RX_READY),
        .out_data  (RX_DATA)
    );

    // Master side: one operation at a time, nothing is queued
    assign mst_req   = MST_START_REQ | MST_RSTART_REQ | MST_RECV_REQ |
                       MST_ACK_REQ | MST_STOP_REQ;
    assign mst_take  = master_on & ~mst_busy_reg & (mst_req | TX_WRITE);
    assign write_collision_set  = master_on & mst_busy_reg & TX_WRITE;
    assign tx_accept = TX_WRITE & ~write_collision_set;
    assign mst_done  = mst_busy_reg & (mst_cnt_reg == 8'h01);
    assign irq_set   = mst_done | (fall9 & (phase_reg != `ISSMC_PH_SKIP) &
                       (phase_reg != `ISSMC_PH_IDLE));

    // Operation timer stands in for the omitted line sequencing
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mst_busy_reg <= 1'b0;
            mst_cnt_reg  <= 8'h00;
        end else if (!master_on) begin
            mst_busy_reg <= 1'b0;
            mst_cnt_reg  <= 8'h00;
        end else if (mst_take) begin
            mst_busy_reg <= 1'b1;
            mst_cnt_reg  <= `ISSMC_MST_OP_CYC;
        end else if (mst_busy_reg) begin
            mst_busy_reg <= ~mst_done;
            mst_cnt_reg  <= mst_cnt_reg - 8'h01;
        end
    end

    // Sticky flags: a hardware set in the clearing cycle wins
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_reg        <= 1'b0;
            write_collision_reg       <= 1'b0;
            ovf_reg        <= 1'b0;
            start_seen_reg <= 1'b0;
            stop_seen_reg  <= 1'b0;
        end else if (!PORT_ENABLE) begin
            irq_reg        <= 1'b0;
            write_collision_reg       <= 1'b0;
            ovf_reg        <= 1'b0;
            start_seen_reg <= 1'b0;
            stop_seen_reg  <= 1'b0;
        end else begin
            irq_reg  <= irq_set | (irq_reg & ~IRQ_CLEAR);
            write_collision_reg <= write_collision_set | (write_collision_reg & ~WRITE_COLLISION_CLEAR);
            ovf_reg  <= (fall8 & (phase_reg == `ISSMC_PH_RX) & ~room) |
                        (ovf_reg & ~OVERFLOW_CLEAR);
            if (start_det) begin
                start_seen_reg <= 1'b1;
                stop_seen_reg  <= 1'b0;
            end else if (stop_det) begin
                start_seen_reg <= 1'b0;
                stop_seen_reg  <= 1'b1;
            end
        end
    end

    // Slave byte engine: bit count, shifting, address phases, acknowledge
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            phase_reg      <= `ISSMC_PH_IDLE;
            cnt_reg        <= 4'h0;
            shift_register <= 8'h00;
            tx_shift_reg   <= 8'h00;
            sda_drive_reg  <= 1'b0;
            rw_reg         <= 1'b0;
            ten_hi_reg     <= 1'b0;
            addr_seq_reg   <= 1'b0;
            tx_need_reg    <= 1'b0;
        end else if (!slave_on || stop_det) begin
            phase_reg     <= `ISSMC_PH_IDLE;
            cnt_reg       <= 4'h0;
            sda_drive_reg <= 1'b0;
            tx_need_reg   <= 1'b0;
            if (!slave_on)
                ten_hi_reg <= 1'b0;
        end else if (start_det) begin
            phase_reg     <= `ISSMC_PH_ADDR;
            cnt_reg       <= 4'h0;
            sda_drive_reg <= 1'b0;
            tx_need_reg   <= 1'b0;
        end else if (phase_reg != `ISSMC_PH_IDLE) begin
            if (scl_rise && cnt_reg != `ISSMC_BIT_ACK) begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg != `ISSMC_BIT_LAST)
                    shift_register <= {shift_register[6:0], sda_sync_reg};
                else if (phase_reg == `ISSMC_PH_TX && sda_sync_reg)
                    phase_reg <= `ISSMC_PH_IDLE; // Master refused: byte stream ends
            end
            if (fall8) begin
                sda_drive_reg <= ack_now;
                addr_seq_reg  <= (phase_reg == `ISSMC_PH_ADDR) |
                                 (phase_reg == `ISSMC_PH_ADDR2);
                case (phase_reg)
                    `ISSMC_PH_ADDR: begin
                        rw_reg <= shift_register[0];
                        if (!ack_now)
                            phase_reg <= `ISSMC_PH_SKIP;
                        else if (gc_hit)
                            phase_reg <= `ISSMC_PH_RX;
                        else if (shift_register[0])
                            phase_reg <= `ISSMC_PH_TX;
                        else if (TEN_BIT_MODE) begin
                            phase_reg  <= `ISSMC_PH_ADDR2;
                            ten_hi_reg <= 1'b0;
                        end else
                            phase_reg <= `ISSMC_PH_RX;
                    end
                    `ISSMC_PH_ADDR2: begin
                        phase_reg  <= ack_now ? `ISSMC_PH_RX : `ISSMC_PH_SKIP;
                        ten_hi_reg <= ack_now;
                    end
                    `ISSMC_PH_TX: begin
                        sda_drive_reg <= 1'b0; // Master owns the acknowledge bit
                    end
                    default: begin
                        sda_drive_reg <= ack_now;
                    end
                endcase
            end else if (fall9) begin
                cnt_reg       <= 4'h0;
                sda_drive_reg <= 1'b0;
                tx_need_reg   <= (phase_reg == `ISSMC_PH_TX);
            end else if (phase_reg == `ISSMC_PH_TX && scl_fall &&
                         cnt_reg != 4'h0 && cnt_reg != `ISSMC_BIT_ACK) begin
                tx_shift_reg  <= {tx_shift_reg[6:0], 1'b0};
                sda_drive_reg <= ~tx_shift_reg[6];
            end else if (tx_need_reg && tx_full_reg) begin
                tx_shift_reg  <= serial_buffer_reg;
                sda_drive_reg <= ~serial_buffer_reg[7];
                tx_need_reg   <= 1'b0;
            end
        end
    end

    // Clock release, update-address, transmit buffer and the clock hold
    assign hold = ~clock_release_reg | ua_hold_reg;
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            clock_release_reg       <= `ISSMC_RST_CKP;
            update_address_flag_reg <= 1'b0;
            ua_hold_reg             <= 1'b0;
            own_address_reg         <= `ISSMC_RST_ADDR;
            serial_buffer_reg       <= 8'h00;
            tx_full_reg             <= 1'b0;
            scl_drive_reg           <= 1'b0;
        end else begin
            if (OWN_ADDRESS_WR)
                own_address_reg <= OWN_ADDRESS_DATA;
            if (tx_accept)
                serial_buffer_reg <= TX_DATA;
            if (tx_accept)
                tx_full_reg <= 1'b1;
            else if (tx_need_reg && tx_full_reg && phase_reg == `ISSMC_PH_TX)
                tx_full_reg <= 1'b0;
            if (!slave_on) begin
                clock_release_reg       <= `ISSMC_RST_CKP;
                update_address_flag_reg <= 1'b0;
                ua_hold_reg             <= 1'b0;
                tx_full_reg             <= 1'b0;
            end else begin
                // Update-address: hardware set wins over the address write
                if (fall8 && ack_now && !gc_hit && TEN_BIT_MODE &&
                    (phase_reg == `ISSMC_PH_ADDR2 ||
                     (phase_reg == `ISSMC_PH_ADDR && !shift_register[0])))
                    update_address_flag_reg <= 1'b1;
                else if (OWN_ADDRESS_WR)
                    update_address_flag_reg <= 1'b0;
                // Address bytes hold the clock without touching clock release
                if (fall9 && addr_seq_reg && update_address_flag_reg)
                    ua_hold_reg <= 1'b1;
                else if (OWN_ADDRESS_WR)
                    ua_hold_reg <= 1'b0;
                // Software write wins so a release is never lost
                if (CLOCK_RELEASE_WR)
                    clock_release_reg <= CLOCK_RELEASE_DATA;
                else if (fall9 && phase_reg == `ISSMC_PH_TX && !tx_full_reg)
                    clock_release_reg <= 1'b0;
                else if (fall9 && phase_reg == `ISSMC_PH_RX && !addr_seq_reg &&
                         STRETCH_ENABLE && rx_nonempty)
                    clock_release_reg <= 1'b0;
            end
            // Pull low only once the line is already low; let go on release
            if (!hold || !slave_on)
                scl_drive_reg <= 1'b0;
            else if (!scl_sync_reg)
                scl_drive_reg <= 1'b1;
        end
    end

    // Open-drain pins only ever drive low
    assign SCL_OUT             = 1'b0;
    assign SCL_OE              = scl_drive_reg;
    assign SDA_OUT             = 1'b0;
    assign SDA_OE              = sda_drive_reg;
    assign OWN_ADDRESS         = own_address_reg;
    assign CLOCK_RELEASE       = clock_release_reg;
    assign RX_VALID            = rx_nonempty;
    assign TX_READY            = ~(master_on & mst_busy_reg);
    assign BUFFER_FULL         = (phase_reg == `ISSMC_PH_TX) ? tx_full_reg : rx_nonempty;
    assign UPDATE_ADDRESS_FLAG = update_address_flag_reg;
    assign READ_WRITE          = rw_reg;
    assign START_SEEN          = start_seen_reg;
    assign STOP_SEEN           = stop_seen_reg;
    assign PORT_IRQ_FLAG       = irq_reg;
    assign WRITE_COLLISION     = write_collision_reg;
    assign RECEIVE_OVERFLOW    = ovf_reg;
    assign MST_BUSY            = mst_busy_reg;
endmodule // issmc_top

//--- tb/issmc_asserts.sv
// Concurrent checks on the serial port's top-level ports
`timescale 1ns/1ps
module issmc_asserts (
    input wire CORE_CLK,
    input wire RESETN,
    input wire SCL_IN,
    input wire SCL_OE,
    input wire PORT_ENABLE,
    input wire MASTER_MODE,
    input wire CLOCK_RELEASE_WR,
    input wire CLOCK_RELEASE_DATA,
    input wire CLOCK_RELEASE,
    input wire TX_WRITE,
    input wire WRITE_COLLISION,
    input wire MST_BUSY,
    input wire PORT_IRQ_FLAG,
    input wire START_SEEN,
    input wire STOP_SEEN,
    input wire MST_START_REQ,
    input wire MST_RSTART_REQ,
    input wire MST_RECV_REQ,
    input wire MST_ACK_REQ,
    input wire MST_STOP_REQ
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    wire any_req = MST_START_REQ || MST_RSTART_REQ || MST_RECV_REQ || MST_ACK_REQ
                   || MST_STOP_REQ || TX_WRITE;
    AST_HOLD_AFTER_LOW: assert property ($rose(SCL_OE) |-> !$past(SCL_IN, 2))
        else $error("clock hold began while the line was high");
    AST_HOLD_WHILE_CLEAR: assert property (SCL_OE && !CLOCK_RELEASE && PORT_ENABLE && !MASTER_MODE |=> SCL_OE)
        else $error("clock hold dropped while release is clear");
    AST_RELEASE_WRITE: assert property (CLOCK_RELEASE_WR |=> CLOCK_RELEASE == $past(CLOCK_RELEASE_DATA))
        else $error("clock release write not reflected next cycle");
    AST_FREE_ONLY_RELEASED: assert property ($fell(SCL_OE) |-> $past(CLOCK_RELEASE) || !$past(PORT_ENABLE) || $past(MASTER_MODE))
        else $error("clock hold ended without release");
    AST_NO_QUEUE: assert property (MASTER_MODE && PORT_ENABLE && MST_BUSY && TX_WRITE |=> WRITE_COLLISION)
        else $error("buffer write during busy did not flag a collision");
    AST_DONE_FLAG: assert property ($fell(MST_BUSY) && PORT_ENABLE |=> PORT_IRQ_FLAG)
        else $error("master operation ended without interrupt flag");
    AST_OP_TAKEN: assert property (MASTER_MODE && PORT_ENABLE && !MST_BUSY && any_req |=> MST_BUSY [*8])
        else $error("master request not held busy");
    AST_DISABLE_CLEARS: assert property (!PORT_ENABLE |=> !START_SEEN && !STOP_SEEN)
        else $error("start or stop status survived port disable");
endmodule // issmc_asserts

bind issmc_top issmc_asserts i_issmc_asserts (.*);

//--- tb/issmc_bus_master.sv
// Behavioural bus master clocking bits at a 160 ns period on open-drain lines
`timescale 1ns/1ps
module issmc_bus_master (
    input  wire scl,
    input  wire sda,
    output reg  scl_oe = 1'b0,
    output reg  sda_oe = 1'b0
);
    // Start condition; the bus is taken only when idle
    task start;
        begin
            wait (scl && sda);
            sda_oe = 1'b1;
            #80 scl_oe = 1'b1;
            #40;
        end
    endtask
    // Nine clocks; a stretching slave stalls the rise, so wait for the line itself
    task xfer(input [8:0] d, output [8:0] q);
        integer i;
        begin
            for (i = 8; i >= 0; i = i - 1) begin
                sda_oe = !d[i];
                #40 scl_oe = 1'b0;
                wait (scl);
                q[i] = sda;
                #80 scl_oe = 1'b1;
                #40;
            end
            sda_oe = 1'b0; // Released line floats to the pull-up
        end
    endtask
    // Stop condition after any clock hold is lifted
    task stop;
        begin
            sda_oe = 1'b1;
            #40 scl_oe = 1'b0;
            wait (scl);
            #80 sda_oe = 1'b0;
            #80;
        end
    endtask
endmodule // issmc_bus_master

//--- tb/issmc_top_tb_top.sv
// Self-checking bench: slave stretching, general call and master events
`timescale 1ns/1ps
module issmc_top_tb_top;
    reg  CORE_CLK = 1'b0, RESETN = 1'b0, PORT_ENABLE = 1'b0, MASTER_MODE = 1'b0;
    reg  TEN_BIT_MODE = 1'b0, STRETCH_ENABLE = 1'b1, GENERAL_CALL_ENABLE = 1'b0;
    reg  OWN_ADDRESS_WR = 1'b0, CLOCK_RELEASE_WR = 1'b0, CLOCK_RELEASE_DATA = 1'b0;
    reg  RX_READY = 1'b0, IRQ_CLEAR = 1'b0, WRITE_COLLISION_CLEAR = 1'b0, OVERFLOW_CLEAR = 1'b0;
    reg  [7:0] OWN_ADDRESS_DATA = 8'h00, TX_DATA = 8'h00;
    reg  [5:0] req = 6'h00;
    reg  [8:0] q;
    wire [7:0] OWN_ADDRESS, RX_DATA;
    wire SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, CLOCK_RELEASE, RX_VALID, TX_READY, BUFFER_FULL;
    wire UPDATE_ADDRESS_FLAG, READ_WRITE, START_SEEN, STOP_SEEN, PORT_IRQ_FLAG;
    wire WRITE_COLLISION, RECEIVE_OVERFLOW, MST_BUSY, m_scl, m_sda;
    integer num_errors = 0, n_checks = 0, cycles = 0, i, k;
    // Wired-AND lines with pull-ups; request vector fans out to the pulses
    wire SCL_IN = !(m_scl | SCL_OE);
    wire SDA_IN = !(m_sda | SDA_OE);
    wire MST_START_REQ = req[0], MST_RSTART_REQ = req[1], MST_RECV_REQ = req[2];
    wire MST_ACK_REQ = req[3], MST_STOP_REQ = req[4], TX_WRITE = req[5];
    issmc_bus_master i_issmc_bus_master (.scl(SCL_IN), .sda(SDA_IN), .scl_oe(m_scl), .sda_oe(m_sda));
    issmc_top i_issmc_top (.*);
    // Clock and hang guard
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end
    task step(input integer n);
        begin
            repeat (n) @(posedge CORE_CLK);
            #1;
        end
    endtask
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected %0s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    // One-cycle write: ca selects clock release, else own address
    task wr(input ca, input [7:0] d);
        begin
            OWN_ADDRESS_DATA = d;
            CLOCK_RELEASE_DATA = d[0];
            OWN_ADDRESS_WR = !ca;
            CLOCK_RELEASE_WR = ca;
            step(1);
            OWN_ADDRESS_WR = 1'b0;
            CLOCK_RELEASE_WR = 1'b0;
        end
    endtask
    // Byte from the master; acknowledge expected low; then let the sync stages settle
    task sb(input [7:0] d);
        begin
            i_issmc_bus_master.xfer({d, 1'b1}, q);
            chk("ack", 8'h00, {7'h00, q[0]});
            step(10);
        end
    endtask
    task pop(input [7:0] d);
        begin
            chk("rx_valid", 8'h01, RX_VALID);
            chk("rx_data", d, RX_DATA);
            RX_READY = 1'b1;
            step(1);
            RX_READY = 1'b0;
        end
    endtask
    task wrap_up;
        begin
            if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        step(6);
        RESETN = 1'b1;
        chk("release", 8'h01, CLOCK_RELEASE);
        chk("scl_oe", 8'h00, SCL_OE);
        chk("own_addr", 8'h00, OWN_ADDRESS);
        PORT_ENABLE = 1'b1;
        wr(0, 8'hA0);
        i_issmc_bus_master.start;
        sb(8'hA0);
        chk("release", 8'h01, CLOCK_RELEASE);
        sb(8'h5A);
        chk("release", 8'h00, CLOCK_RELEASE);
        chk("scl_oe", 8'h01, SCL_OE);
        wr(1, 8'h01);
        chk("release", 8'h01, CLOCK_RELEASE);
        pop(8'hA0);
        pop(8'h5A);
        i_issmc_bus_master.stop;
        TEN_BIT_MODE = 1'b1;
        STRETCH_ENABLE = 1'b0;
        GENERAL_CALL_ENABLE = 1'b1;
        wr(0, 8'hF2);
        i_issmc_bus_master.start;
        sb(8'hF2);
        chk("ua", 8'h01, UPDATE_ADDRESS_FLAG);
        chk("scl_oe", 8'h01, SCL_OE);
        chk("release", 8'h01, CLOCK_RELEASE);
        wr(0, 8'h3C);
        sb(8'h3C);
        chk("ua", 8'h01, UPDATE_ADDRESS_FLAG);
        wr(0, 8'hF2);
        sb(8'h11);
        chk("release", 8'h01, CLOCK_RELEASE);
        i_issmc_bus_master.stop;
        pop(8'hF2);
        pop(8'h3C);
        pop(8'h11);
        IRQ_CLEAR = 1'b1;
        step(1);
        IRQ_CLEAR = 1'b0;
        i_issmc_bus_master.start;
        sb(8'h00);
        chk("ua", 8'h00, UPDATE_ADDRESS_FLAG);
        chk("irq", 8'h01, PORT_IRQ_FLAG);
        sb(8'h22);
        i_issmc_bus_master.stop;
        pop(8'h00);
        pop(8'h22);
        TEN_BIT_MODE = 1'b0;
        wr(0, 8'hA0);
        i_issmc_bus_master.start;
        sb(8'hA1);
        chk("release", 8'h00, CLOCK_RELEASE);
        chk("rw", 8'h01, READ_WRITE);
        pop(8'hA1);
        TX_DATA = 8'hC3;
        req = 6'h20;
        step(1);
        req = 6'h00;
        chk("full", 8'h01, BUFFER_FULL);
        wr(1, 8'h01);
        i_issmc_bus_master.xfer(9'h1FF, q);
        chk("tx_byte", 8'hC3, q[8:1]);
        i_issmc_bus_master.stop;
        MASTER_MODE = 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            IRQ_CLEAR = 1'b1;
            WRITE_COLLISION_CLEAR = 1'b1;
            step(1);
            IRQ_CLEAR = 1'b0;
            WRITE_COLLISION_CLEAR = 1'b0;
            req = 6'h01 << i;
            step(1);
            req = 6'h20;
            chk("busy", 8'h01, MST_BUSY);
            chk("tx_ready", 8'h00, TX_READY);
            step(1);
            req = 6'h00;
            chk("write_collision", 8'h01, WRITE_COLLISION);
            for (k = 0; k < 40 && MST_BUSY !== 1'b0; k = k + 1) step(1);
            step(1);
            chk("irq", 8'h01, PORT_IRQ_FLAG);
        end
        PORT_ENABLE = 1'b0;
        step(2);
        chk("start_seen", 8'h00, START_SEEN);
        chk("stop_seen", 8'h00, STOP_SEEN);
        chk("overflow", 8'h00, RECEIVE_OVERFLOW);
        wrap_up;
    end
endmodule // issmc_top_tb_top
